// >>> status_register_sets.sv
// Register bank for the questionable power, questionable data and user status sets
`timescale 1ns/10ps
`default_nettype none

module status_register_sets
  import status_sets_pkg::*;
(
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire status_sets_pkg::bus_addr_type addr_in,
  input wire status_sets_pkg::bus_data_type wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire status_sets_pkg::status_word_type qp_cond_in,
  input wire logic preset_in,
  output status_sets_pkg::bus_data_type rd_data_out,
  output status_sets_pkg::status_word_type qd_ptr_out,
  output logic qp_summary_out,
  output logic user_summary_out,
  output logic irq_out
);

  bank_state_type st_r;
  bank_state_type st_nxt;
  status_word_type qp_events;
  status_word_type usr_events;
  status_word_type usr_cond;
  status_word_type wr_word;
  logic qp_sum;
  logic usr_sum;
  logic qp_rd_clr;
  logic usr_rd_clr;
  logic usr_pulse;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic strobe, input bus_addr_type a,
                               input bus_addr_type offs);
    hit = strobe && (a == offs);
  endfunction

  function automatic bus_data_type widen(input status_word_type w);
    widen = {1'b0, w};
  endfunction

  // Bit 15 is outside the documented range and is dropped
  assign wr_word = wr_data_in[`SS_WORD_W-1:0];
  assign qp_rd_clr = hit(rd_in, addr_in, `SS_QP_EVT_ADDR);
  assign usr_rd_clr = hit(rd_in, addr_in, `SS_USR_EVT_ADDR);
  assign usr_pulse = hit(wr_in, addr_in, `SS_USR_PULSE_ADDR);

  // ----------------------------------------------------------------
  // Register sets
  // ----------------------------------------------------------------
  status_event_set qp_set (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .cond_in(qp_cond_in),
    .rise_mask_in(st_r.qp_ptr),
    .fall_mask_in(st_r.qp_ntr),
    .enable_in(st_r.qp_en),
    .clear_in(qp_rd_clr),
    .preset_in(preset_in),
    .event_out(qp_events),
    .summary_out(qp_sum)
  );

  status_cond_pulse usr_pulser (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .pulse_in(usr_pulse),
    .weight_in(wr_word),
    .cond_out(usr_cond)
  );

  status_event_set usr_set (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .cond_in(usr_cond),
    .rise_mask_in(`SS_USR_RISE_MASK),
    .fall_mask_in(`SS_USR_FALL_MASK),
    .enable_in(st_r.usr_en),
    .clear_in(usr_rd_clr),
    .preset_in(preset_in),
    .event_out(usr_events),
    .summary_out(usr_sum)
  );

  // ----------------------------------------------------------------
  // Bus writes, reads and interrupt
  // ----------------------------------------------------------------
  // Preset is deliberately absent here: filters and masks survive it
  always_comb
  begin
    st_nxt = st_r;
    if (hit(wr_in, addr_in, `SS_QP_NTR_ADDR))
      st_nxt.qp_ntr = wr_word;
    if (hit(wr_in, addr_in, `SS_QP_PTR_ADDR))
      st_nxt.qp_ptr = wr_word;
    if (hit(wr_in, addr_in, `SS_QP_EN_ADDR))
      st_nxt.qp_en = wr_word;
    if (hit(wr_in, addr_in, `SS_QD_PTR_ADDR))
      st_nxt.qd_ptr = wr_word;
    if (hit(wr_in, addr_in, `SS_USR_EN_ADDR))
      st_nxt.usr_en = wr_word;
    if (hit(wr_in, addr_in, `SS_IRQ_MASK_ADDR))
      st_nxt.irq_mask = wr_data_in[`SS_IRQ_W-1:0];
    // Write one to clear; a summary still high sets the bit again
    if (hit(wr_in, addr_in, `SS_IRQ_STAT_ADDR))
      st_nxt.irq_stat = st_r.irq_stat & ~wr_data_in[`SS_IRQ_W-1:0];
    st_nxt.irq_stat[`SS_IRQ_QP_BIT] = st_nxt.irq_stat[`SS_IRQ_QP_BIT] | qp_sum;
    st_nxt.irq_stat[`SS_IRQ_USR_BIT] = st_nxt.irq_stat[`SS_IRQ_USR_BIT] | usr_sum;
    st_nxt.irq = |(st_r.irq_stat & st_r.irq_mask);
    // Read data stand for one cycle only, zero otherwise
    st_nxt.rd_data = '0;
    if (rd_in)
    begin
      unique case (addr_in)
        `SS_QP_EVT_ADDR: st_nxt.rd_data = widen(qp_events);
        `SS_QP_COND_ADDR: st_nxt.rd_data = widen(qp_cond_in);
        `SS_QP_NTR_ADDR: st_nxt.rd_data = widen(st_r.qp_ntr);
        `SS_QP_PTR_ADDR: st_nxt.rd_data = widen(st_r.qp_ptr);
        `SS_QP_EN_ADDR: st_nxt.rd_data = widen(st_r.qp_en);
        `SS_QD_PTR_ADDR: st_nxt.rd_data = widen(st_r.qd_ptr);
        `SS_USR_EN_ADDR: st_nxt.rd_data = widen(st_r.usr_en);
        `SS_USR_EVT_ADDR: st_nxt.rd_data = widen(usr_events);
        `SS_USR_COND_ADDR: st_nxt.rd_data = widen(usr_cond);
        `SS_IRQ_STAT_ADDR: st_nxt.rd_data = {14'h0000, st_r.irq_stat};
        `SS_IRQ_MASK_ADDR: st_nxt.rd_data = {14'h0000, st_r.irq_mask};
        default: st_nxt.rd_data = '0;
      endcase
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign rd_data_out = st_r.rd_data;
  assign qd_ptr_out = st_r.qd_ptr;
  assign irq_out = st_r.irq;

  // Summaries pass through one more flop so that outputs stay registered
  logic qp_sum_r;
  logic usr_sum_r;

  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      qp_sum_r <= 1'b0;
      usr_sum_r <= 1'b0;
    end
    else
    begin
      qp_sum_r <= qp_sum;
      usr_sum_r <= usr_sum;
    end
  end

  assign qp_summary_out = qp_sum_r;
  assign user_summary_out = usr_sum_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_qp_event_read: assert property (@(posedge clock_in) disable iff (!nrst_in)
    hit(rd_in, addr_in, `SS_QP_EVT_ADDR) |=> (rd_data_out == {1'b0, $past(qp_events)}))
    else $error("power event read returned wrong sum");

  a_usr_event_read: assert property (@(posedge clock_in) disable iff (!nrst_in)
    hit(rd_in, addr_in, `SS_USR_EVT_ADDR) |=> (rd_data_out == {1'b0, $past(usr_events)}))
    else $error("user event read returned wrong sum");

  a_usr_read_clear: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (hit(rd_in, addr_in, `SS_USR_EVT_ADDR) && !usr_pulse && (usr_cond == 15'h0000))
    |=> (usr_events == 15'h0000))
    else $error("user event register not cleared by its read");

  a_qp_ntr_load: assert property (@(posedge clock_in) disable iff (!nrst_in)
    hit(wr_in, addr_in, `SS_QP_NTR_ADDR) |=> (st_r.qp_ntr == $past(wr_data_in[14:0])))
    else $error("power falling filter not loaded");

  a_qp_ptr_load: assert property (@(posedge clock_in) disable iff (!nrst_in)
    hit(wr_in, addr_in, `SS_QP_PTR_ADDR) |=> (st_r.qp_ptr == $past(wr_data_in[14:0])))
    else $error("power rising filter not loaded");

  a_qd_ptr_load: assert property (@(posedge clock_in) disable iff (!nrst_in)
    hit(wr_in, addr_in, `SS_QD_PTR_ADDR) |=> (qd_ptr_out == $past(wr_data_in[14:0])))
    else $error("data rising filter not loaded");

  a_usr_en_load: assert property (@(posedge clock_in) disable iff (!nrst_in)
    hit(wr_in, addr_in, `SS_USR_EN_ADDR) ##1 !wr_in |=> (st_r.usr_en == $past(wr_data_in[14:0], 2)))
    else $error("user enable mask not loaded");

  a_preset_keeps: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (preset_in && !wr_in) |=> ($stable(st_r.qp_ntr) && $stable(st_r.qp_ptr)
      && $stable(st_r.qp_en) && $stable(st_r.qd_ptr) && $stable(st_r.usr_en)))
    else $error("preset altered a filter or mask");

  a_filter_read: assert property (@(posedge clock_in) disable iff (!nrst_in)
    hit(rd_in, addr_in, `SS_QP_PTR_ADDR) |=> (rd_data_out == {1'b0, $past(st_r.qp_ptr)}))
    else $error("filter read returned wrong contents");

  // ----------------------------------------------------------------
  // Further read, write and interrupt checks
  // ----------------------------------------------------------------
  // Read data must fall back to zero so that a stale word never looks fresh
  a_rd_idle_zero: assert property (@(posedge clock_in) disable iff (!nrst_in)
    !rd_in
    |=> (rd_data_out == 16'h0000))
    else $error("read data not zero outside a read");

  a_rd_top_bit: assert property (@(posedge clock_in) disable iff (!nrst_in)
    rd_in
    |=> !rd_data_out[`SS_DATA_W-1])
    else $error("read data bit 15 is not zero");

  a_unmapped_read: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (rd_in && (addr_in > `SS_IRQ_MASK_ADDR))
    |=> (rd_data_out == 16'h0000))
    else $error("unmapped read not zero");

  a_pulse_addr_read: assert property (@(posedge clock_in) disable iff (!nrst_in)
    hit(rd_in, addr_in, `SS_USR_PULSE_ADDR)
    |=> (rd_data_out == 16'h0000))
    else $error("write only pulse index read not zero");

  a_ntr_read: assert property (@(posedge clock_in) disable iff (!nrst_in)
    hit(rd_in, addr_in, `SS_QP_NTR_ADDR)
    |=> (rd_data_out == {1'b0, $past(st_r.qp_ntr)}))
    else $error("falling filter read wrong");

  a_qp_en_read: assert property (@(posedge clock_in) disable iff (!nrst_in)
    hit(rd_in, addr_in, `SS_QP_EN_ADDR)
    |=> (rd_data_out == {1'b0, $past(st_r.qp_en)}))
    else $error("power enable read wrong");

  a_qd_ptr_read: assert property (@(posedge clock_in) disable iff (!nrst_in)
    hit(rd_in, addr_in, `SS_QD_PTR_ADDR)
    |=> (rd_data_out == {1'b0, $past(st_r.qd_ptr)}))
    else $error("data rising filter read wrong");

  a_usr_en_read: assert property (@(posedge clock_in) disable iff (!nrst_in)
    hit(rd_in, addr_in, `SS_USR_EN_ADDR)
    |=> (rd_data_out == {1'b0, $past(st_r.usr_en)}))
    else $error("user enable read wrong");

  a_qp_cond_read: assert property (@(posedge clock_in) disable iff (!nrst_in)
    hit(rd_in, addr_in, `SS_QP_COND_ADDR)
    |=> (rd_data_out == {1'b0, $past(qp_cond_in)}))
    else $error("power condition read wrong");

  a_usr_cond_read: assert property (@(posedge clock_in) disable iff (!nrst_in)
    hit(rd_in, addr_in, `SS_USR_COND_ADDR)
    |=> (rd_data_out == {1'b0, $past(usr_cond)}))
    else $error("user condition read wrong");

  a_irq_stat_read: assert property (@(posedge clock_in) disable iff (!nrst_in)
    hit(rd_in, addr_in, `SS_IRQ_STAT_ADDR)
    |=> (rd_data_out == {14'h0000, $past(st_r.irq_stat)}))
    else $error("interrupt status read wrong");

  a_irq_mask_read: assert property (@(posedge clock_in) disable iff (!nrst_in)
    hit(rd_in, addr_in, `SS_IRQ_MASK_ADDR)
    |=> (rd_data_out == {14'h0000, $past(st_r.irq_mask)}))
    else $error("interrupt mask read wrong");

  a_qp_en_load: assert property (@(posedge clock_in) disable iff (!nrst_in)
    hit(wr_in, addr_in, `SS_QP_EN_ADDR)
    |=> (st_r.qp_en == $past(wr_data_in[`SS_WORD_W-1:0])))
    else $error("power enable not loaded");

  a_irq_mask_load: assert property (@(posedge clock_in) disable iff (!nrst_in)
    hit(wr_in, addr_in, `SS_IRQ_MASK_ADDR)
    |=> (st_r.irq_mask == $past(wr_data_in[`SS_IRQ_W-1:0])))
    else $error("interrupt mask not loaded");

  // Filters and masks move only on their own writes
  a_cfg_hold: assert property (@(posedge clock_in) disable iff (!nrst_in)
    !wr_in
    |=> ($stable(st_r.qp_ntr) && $stable(st_r.qp_ptr) && $stable(st_r.qp_en)
      && $stable(st_r.qd_ptr) && $stable(st_r.usr_en) && $stable(st_r.irq_mask)))
    else $error("filter or mask changed without a write");

  a_qp_read_clear: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (hit(rd_in, addr_in, `SS_QP_EVT_ADDR) && (qp_cond_in == $past(qp_cond_in)))
    |=> (qp_events == 15'h0000))
    else $error("power event register not cleared by its read");

  a_preset_clears: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (preset_in && (qp_cond_in == $past(qp_cond_in)) && (usr_cond == 15'h0000))
    |=> ((qp_events == 15'h0000) && (usr_events == 15'h0000)))
    else $error("preset did not clear the event registers");

  a_pulse_reaches_cond: assert property (@(posedge clock_in) disable iff (!nrst_in)
    usr_pulse
    |=> (usr_cond == $past(wr_word)))
    else $error("pulse weight did not reach user condition");

  a_irq_qp_set: assert property (@(posedge clock_in) disable iff (!nrst_in)
    qp_sum
    |=> st_r.irq_stat[`SS_IRQ_QP_BIT])
    else $error("power summary did not set interrupt status");

  a_irq_usr_set: assert property (@(posedge clock_in) disable iff (!nrst_in)
    usr_sum
    |=> st_r.irq_stat[`SS_IRQ_USR_BIT])
    else $error("user summary did not set interrupt status");

  a_irq_w1c: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (hit(wr_in, addr_in, `SS_IRQ_STAT_ADDR) && (wr_data_in[`SS_IRQ_W-1:0] == 2'b11) && !qp_sum && !usr_sum)
    |=> (st_r.irq_stat == 2'b00))
    else $error("interrupt status not cleared by write one");

  a_qp_summary_out: assert property (@(posedge clock_in) disable iff (!nrst_in)
    ##1
    (qp_summary_out == $past(qp_sum)))
    else $error("power summary output does not follow its set");

  a_usr_summary_out: assert property (@(posedge clock_in) disable iff (!nrst_in)
    ##1
    (user_summary_out == $past(usr_sum)))
    else $error("user summary output does not follow its set");

endmodule

`default_nettype wire

// >>> status_sets_cfg.svh
// Offsets, widths and reset values of the status register sets
`ifndef STATUS_SETS_CFG_SVH
`define STATUS_SETS_CFG_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define SS_WORD_W 15
`define SS_DATA_W 16
`define SS_ADDR_W 4
`define SS_IRQ_W 2

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SS_QP_EVT_ADDR 4'h0
`define SS_QP_COND_ADDR 4'h1
`define SS_QP_NTR_ADDR 4'h2
`define SS_QP_PTR_ADDR 4'h3
`define SS_QP_EN_ADDR 4'h4
`define SS_QD_PTR_ADDR 4'h5
`define SS_USR_EN_ADDR 4'h6
`define SS_USR_EVT_ADDR 4'h7
`define SS_USR_PULSE_ADDR 4'h8
`define SS_USR_COND_ADDR 4'h9
`define SS_IRQ_STAT_ADDR 4'hA
`define SS_IRQ_MASK_ADDR 4'hB

// ----------------------------------------------------------------
// Interrupt status bits and fixed filters
// ----------------------------------------------------------------
`define SS_IRQ_QP_BIT 0
`define SS_IRQ_USR_BIT 1
`define SS_USR_RISE_MASK 15'h7FFF
`define SS_USR_FALL_MASK 15'h0000
`define SS_RESET_WORD 15'h0000

`endif

// >>> status_sets_pkg.sv
// Types shared by the status register set modules
`include "status_sets_cfg.svh"

package status_sets_pkg;

  typedef logic [`SS_WORD_W-1:0] status_word_type;
  typedef logic [`SS_DATA_W-1:0] bus_data_type;
  typedef logic [`SS_ADDR_W-1:0] bus_addr_type;
  typedef logic [`SS_IRQ_W-1:0] irq_bits_type;

  typedef struct packed {
    status_word_type cond_last;
    status_word_type events;
    logic summary;
  } event_state_type;

  typedef struct packed {
    status_word_type cond;
  } pulse_state_type;

  typedef struct packed {
    status_word_type qp_ntr;
    status_word_type qp_ptr;
    status_word_type qp_en;
    status_word_type qd_ptr;
    status_word_type usr_en;
    irq_bits_type irq_stat;
    irq_bits_type irq_mask;
    bus_data_type rd_data;
    logic irq;
  } bank_state_type;

endpackage

// >>> status_event_set.sv
// One event register with transition filters, read clear and summary bit
`timescale 1ns/10ps
`default_nettype none

module status_event_set
  import status_sets_pkg::*;
(
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire status_sets_pkg::status_word_type cond_in,
  input wire status_sets_pkg::status_word_type rise_mask_in,
  input wire status_sets_pkg::status_word_type fall_mask_in,
  input wire status_sets_pkg::status_word_type enable_in,
  input wire logic clear_in,
  input wire logic preset_in,
  output status_sets_pkg::status_word_type event_out,
  output logic summary_out
);

  event_state_type st_r;
  event_state_type st_nxt;
  status_word_type set_bits;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    set_bits = (cond_in & ~st_r.cond_last & rise_mask_in)
             | (~cond_in & st_r.cond_last & fall_mask_in);
    st_nxt.cond_last = cond_in;
    // A new transition in the clearing cycle is kept, not lost
    st_nxt.events = ((clear_in || preset_in) ? `SS_RESET_WORD : st_r.events)
                  | set_bits;
    st_nxt.summary = |(st_r.events & enable_in);
  end

  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign event_out = st_r.events;
  assign summary_out = st_r.summary;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_event_rise_latch: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (|(cond_in & ~st_r.cond_last & rise_mask_in))
    |=> (|(st_r.events & $past(cond_in & ~st_r.cond_last & rise_mask_in))))
    else $error("rising condition with filter set did not latch event");

  a_event_read_clear: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (clear_in && (set_bits == `SS_RESET_WORD)) |=> (st_r.events == `SS_RESET_WORD))
    else $error("event register not cleared after read");

  a_summary_follows: assert property (@(posedge clock_in) disable iff (!nrst_in)
    ##1 (summary_out == |($past(st_r.events) & $past(enable_in))))
    else $error("summary does not match masked events");

endmodule

`default_nettype wire

// >>> status_cond_pulse.sv
// Condition register whose bits rest at zero and are pulsed by command
`timescale 1ns/10ps
`default_nettype none

module status_cond_pulse
  import status_sets_pkg::*;
(
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic pulse_in,
  input wire status_sets_pkg::status_word_type weight_in,
  output status_sets_pkg::status_word_type cond_out
);

  pulse_state_type st_r;
  pulse_state_type st_nxt;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // One cycle high is enough for the event set to see both edges
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.cond = pulse_in ? weight_in : `SS_RESET_WORD;
  end

  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign cond_out = st_r.cond;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_pulse_one_cycle: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (pulse_in ##1 !pulse_in) |=> (cond_out == `SS_RESET_WORD))
    else $error("user condition bits did not return to zero");

  a_pulse_weight: assert property (@(posedge clock_in) disable iff (!nrst_in)
    pulse_in |=> (cond_out == $past(weight_in)))
    else $error("pulsed condition bits differ from weight");

endmodule

`default_nettype wire

// >>> status_bus_ctrl.sv
// Remote controller model that issues register writes and reads
`timescale 1ns/10ps
`default_nettype none

module status_bus_ctrl
  import status_sets_pkg::*;
(
  input wire logic clock_in,
  input wire status_sets_pkg::bus_data_type rd_data_in,
  output status_sets_pkg::bus_addr_type addr_out,
  output status_sets_pkg::bus_data_type wr_data_out,
  output logic wr_out,
  output logic rd_out
);
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  initial
  begin
    addr_out = 4'h0;
    wr_data_out = 16'h0000;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end

  // Strobe is left high on return so a read may follow with no gap
  task automatic wr_reg(input bus_addr_type a, input bus_data_type v);
    @(posedge clock_in);
    addr_out <= a;
    wr_data_out <= v;
    wr_out <= 1'b1;
    rd_out <= 1'b0;
  endtask

  task automatic rd_reg(input bus_addr_type a, output bus_data_type v);
    @(posedge clock_in);
    addr_out <= a;
    rd_out <= 1'b1;
    wr_out <= 1'b0;
    @(posedge clock_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    #1 v = rd_data_in;
  endtask

  // Released lines show the inverse so stale values never pass for valid
  task automatic idle();
    @(posedge clock_in);
    wr_out <= 1'b0;
    rd_out <= 1'b0;
    addr_out <= ~addr_out;
    wr_data_out <= ~wr_data_out;
  endtask
endmodule

`default_nettype wire

// >>> status_register_sets_tb.sv
// Self-checking bench for the status register bank
`timescale 1ns/10ps
`default_nettype none

module status_register_sets_tb;
  import status_sets_pkg::*;

  logic clock_in;
  logic nrst_in;
  logic preset_in;
  status_word_type qp_cond_in;
  status_word_type qd_ptr;
  bus_addr_type addr;
  bus_data_type wr_data;
  bus_data_type rd_data;
  logic wr;
  logic rd;
  logic qp_sum;
  logic usr_sum;
  logic irq;
  int num_errors = 0;
  int total_checks = 0;
  int seed = 9;
  int cfg [16];
  int qp_ev;
  int usr_ev;
  int prev_cond;
  int irq_st;
  int w;

  status_register_sets status_register_sets_inst (
    .clock_in(clock_in), .nrst_in(nrst_in), .addr_in(addr), .wr_data_in(wr_data),
    .wr_in(wr), .rd_in(rd), .qp_cond_in(qp_cond_in), .preset_in(preset_in),
    .rd_data_out(rd_data), .qd_ptr_out(qd_ptr), .qp_summary_out(qp_sum),
    .user_summary_out(usr_sum), .irq_out(irq));

  status_bus_ctrl status_bus_ctrl_inst (
    .clock_in(clock_in), .rd_data_in(rd_data), .addr_out(addr),
    .wr_data_out(wr_data), .wr_out(wr), .rd_out(rd));

  initial
  begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end

  // ----------------------------------------------------------------
  // Compare and bus helpers
  // ----------------------------------------------------------------
  task automatic chk_data(input bus_data_type got, input int exp);
    total_checks++;
    if (got !== bus_data_type'(exp))
    begin
      num_errors++;
      $display("[ERR] %0t data %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input bus_addr_type a, input int exp);
    bus_data_type v;
    status_bus_ctrl_inst.rd_reg(a, v);
    chk_data(v, exp);
  endtask

  task automatic wr_cfg(input bus_addr_type a, input int v);
    status_bus_ctrl_inst.wr_reg(a, bus_data_type'(v));
    status_bus_ctrl_inst.idle();
    cfg[a] = v & 32'h7FFF;
  endtask

  // Only the rising or falling edges let through by the filters latch
  task automatic set_cond(input int v);
    int rise;
    int fall;
    rise = v & ~prev_cond;
    fall = prev_cond & ~v;
    qp_ev |= (rise & cfg[3]) | (fall & cfg[2]);
    prev_cond = v;
    @(posedge clock_in);
    qp_cond_in <= status_word_type'(v);
    repeat (5) @(posedge clock_in);
  endtask

  task automatic chk_sums();
    if ((qp_ev & cfg[4]) != 0)
      irq_st |= 1;
    if ((usr_ev & cfg[6]) != 0)
      irq_st |= 2;
    chk_bit(qp_sum, (qp_ev & cfg[4]) != 0);
    chk_bit(usr_sum, (usr_ev & cfg[6]) != 0);
    chk_bit(irq, (irq_st & cfg[11]) != 0);
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    repeat (8000) @(posedge clock_in);
    num_errors++;
    test_done();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    nrst_in = 1'b0;
    preset_in = 1'b0;
    qp_cond_in = 15'h0000;
    qp_ev = 0;
    usr_ev = 0;
    prev_cond = 0;
    irq_st = 0;
    foreach (cfg[i])
      cfg[i] = 0;
    repeat (8) @(posedge clock_in);
    nrst_in <= 1'b1;
    for (int a = 0; a < 16; a++)
      rd_chk(bus_addr_type'(a), 0);
    $display("test reset_values done");
    // Middle round writes bit 15 too, which must be dropped
    for (int r = 0; r < 3; r++)
    begin
      for (int a = 2; a < 7; a++)
      begin
        w = (r == 1) ? 32'hFFFF : $random(seed) & 32'h7FFF;
        wr_cfg(bus_addr_type'(a), w);
      end
      for (int a = 2; a < 7; a++)
        rd_chk(bus_addr_type'(a), cfg[a]);
      chk_data({1'b0, qd_ptr}, cfg[5]);
    end
    status_bus_ctrl_inst.wr_reg(4'h1, 16'h7FFF);
    status_bus_ctrl_inst.wr_reg(4'hF, 16'h1234);
    status_bus_ctrl_inst.idle();
    rd_chk(4'h1, 0);
    rd_chk(4'hF, 0);
    $display("test filters_masks done");
    wr_cfg(4'h4, 32'h7FFF);
    for (int i = 0; i < 8; i++)
    begin
      set_cond($random(seed) & 32'h7FFF);
      chk_sums();
      rd_chk(4'h1, prev_cond);
      if (i % 2 == 1)
      begin
        rd_chk(4'h0, qp_ev);
        qp_ev = 0;
        rd_chk(4'h0, 0);
      end
    end
    repeat (4) status_bus_ctrl_inst.idle();
    chk_sums();
    $display("test power_events done");
    wr_cfg(4'h6, $random(seed) & 32'h7FFF);
    for (int i = 0; i < 4; i++)
    begin
      w = (i == 0) ? 0 : $random(seed) & 32'h7FFF;
      status_bus_ctrl_inst.wr_reg(4'h8, bus_data_type'(w));
      rd_chk(4'h9, w);
      rd_chk(4'h9, 0);
      usr_ev |= w;
      repeat (3) status_bus_ctrl_inst.idle();
      chk_sums();
    end
    rd_chk(4'h7, usr_ev);
    usr_ev = 0;
    rd_chk(4'h7, 0);
    $display("test user_set done");
    wr_cfg(4'hB, 32'h0003);
    repeat (3) status_bus_ctrl_inst.idle();
    chk_sums();
    rd_chk(4'hA, irq_st);
    status_bus_ctrl_inst.wr_reg(4'hA, 16'h0003);
    status_bus_ctrl_inst.idle();
    irq_st = 0;
    repeat (3) status_bus_ctrl_inst.idle();
    rd_chk(4'hA, 0);
    chk_sums();
    $display("test interrupt done");
    set_cond(prev_cond ^ 32'h7FFF);
    @(posedge clock_in);
    preset_in <= 1'b1;
    @(posedge clock_in);
    preset_in <= 1'b0;
    qp_ev = 0;
    for (int a = 2; a < 7; a++)
      rd_chk(bus_addr_type'(a), cfg[a]);
    rd_chk(4'h0, 0);
    $display("test preset done");
    test_done();
  end
endmodule

`default_nettype wire
